// ---- hw/clsd_pkg.sv ----
/*
  Shared constants and types for the compact load/store decoder: opcode tags,
  field positions, access sizes, operation codes and the bundles that carry
  memory requests, register selects and register write-back.
  Assumes a 32-bit core with eight low registers and a halfword-aligned PC.
*/
// How it works
// - Register offset: address is base plus index
// - Word/byte L,B: word/byte store, word/byte load
// - Byte store writes only the low byte
// - Halfword store writes source bits 0-15
// - Unsigned halfword load clears bits 16-31
// - Signed byte load copies bit 7 upward
// - Signed halfword load copies bit 15 upward
// - Select S,H: store, load, signed byte, signed half
// - Immediate byte: base plus unscaled five-bit field
// - Immediate word: five-bit field shifted left two
// - Immediate halfword: base plus six-bit offset
// - Immediate halfword: field shifted left one
// - Immediate halfword direction: store, or zero-extended load
// - Cycle count equals equivalent 32-bit instruction
// - PC-relative load clears PC bit 1
// - PC-relative uses PC plus four, field times four
package clsd_pkg;

  // Format tags in the top opcode bits
  localparam logic [4:0]  PCREL_TAG    = 5'h09;
  localparam logic [3:0]  REGOFF_TAG   = 4'h5;
  localparam logic [2:0]  IMMWB_TAG    = 3'h3;
  localparam logic [3:0]  IMMH_TAG     = 4'h8;

  // Field positions
  localparam int          RD_LSB       = 0;
  localparam int          RB_LSB       = 3;
  localparam int          RO_LSB       = 6;
  localparam int          OFF5_LSB     = 6;
  localparam int          PCRD_LSB     = 8;
  localparam int          W8_LSB       = 0;
  localparam int          LOAD_BIT     = 11;
  localparam int          BYTE_BIT     = 10;
  localparam int          SIGN_BIT     = 10;
  localparam int          HALF_BIT     = 11;
  localparam int          EXT_BIT      = 9;
  localparam int          IMM_BYTE_BIT = 12;

  // PC read-ahead and word alignment of the PC base
  localparam logic [31:0] PC_AHEAD     = 32'h0000_0004;
  localparam logic [31:0] PC_BIT1_CLR  = 32'hFFFF_FFFD;

  // Reset values
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  localparam logic [2:0]  SEL_RST      = 3'h0;

  typedef enum logic [3:0] {
    no_op               = 4'h0,
    word_store_op       = 4'h1,
    byte_store_op       = 4'h2,
    word_load_op        = 4'h3,
    byte_load_op        = 4'h4,
    half_store_op       = 4'h5,
    half_load_op        = 4'h6,
    signed_byte_load_op = 4'h7,
    signed_half_load_op = 4'h8
  } clsd_op_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } clsd_size_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_ACCESS    = 2'b01,
    ST_WAIT      = 2'b10,
    ST_WRITEBACK = 2'b11
  } clsd_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    clsd_size_t  size;
    logic        write;
  } clsd_mem_req_t;

  typedef struct packed {
    logic [2:0] base_sel;
    logic [2:0] index_sel;
    logic [2:0] data_sel;
  } clsd_rsel_t;

  typedef struct packed {
    logic [2:0]  sel;
    logic [31:0] data;
  } clsd_wb_t;

endpackage : clsd_pkg

// ---- hw/clsd_extend.sv ----
/*
  Load data extender: widens a returned byte or halfword to 32 bits,
  by zero or sign fill according to the load operation.
  Assumes memory returns the addressed item in the low bits of the word.
*/
`timescale 1ns/1ps
module clsd_extend (
  // Operation and raw data
  input  wire clsd_pkg::clsd_op_t op,
  input  wire logic [31:0]        raw,
  // Extended result
  output wire logic [31:0]        result
);

  // Fill bits for the two sign-extending loads
  wire byte_op   = (op == clsd_pkg::byte_load_op) || (op == clsd_pkg::signed_byte_load_op);
  wire half_op   = (op == clsd_pkg::half_load_op) || (op == clsd_pkg::signed_half_load_op);
  wire byte_fill = (op == clsd_pkg::signed_byte_load_op) & raw[7];
  wire half_fill = (op == clsd_pkg::signed_half_load_op) & raw[15];

  // One selector per result bit
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (i < 8) begin : g_low
        assign result[i] = raw[i];
      end else if (i < 16) begin : g_mid
        assign result[i] = byte_op ? byte_fill : raw[i];
      end else begin : g_high
        assign result[i] = byte_op ? byte_fill : (half_op ? half_fill : raw[i]);
      end
    end
  endgenerate

endmodule : clsd_extend

// ---- hw/clsd_decode.sv ----
/*
  Compact load/store decoder and executor for the register-offset,
  sign-extended, immediate word/byte, immediate halfword and PC-relative
  load formats. Forms the address, drives one memory access, extends
  loaded data and writes it back to a low register.
  Assumes a combinational register-file read, a memory that takes a request
  on mem_ready and returns load data with mem_rvalid on a later cycle.
*/
`timescale 1ns/1ps
module clsd_decode (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // Instruction in
  input  wire logic                    instr_valid,
  output wire logic                    instr_ready,
  input  wire logic [15:0]             instr,
  input  wire logic [31:0]             instr_pc,
  output wire logic                    instr_done,
  output wire logic                    instr_fault,
  // Register file read
  output wire clsd_pkg::clsd_rsel_t    rf_sel,
  input  wire logic [31:0]             rf_base_val,
  input  wire logic [31:0]             rf_index_val,
  input  wire logic [31:0]             rf_data_val,
  // Register file write-back
  output wire logic                    rf_we,
  output wire clsd_pkg::clsd_wb_t      rf_wb,
  // Memory data interface
  output wire logic                    mem_valid,
  output wire clsd_pkg::clsd_mem_req_t mem_req,
  input  wire logic                    mem_ready,
  input  wire logic                    mem_rvalid,
  input  wire logic [31:0]             mem_rdata
);

  clsd_pkg::clsd_state_t   state_reg,  state_next;
  clsd_pkg::clsd_mem_req_t req_reg,    req_next;
  clsd_pkg::clsd_op_t      op_reg,     op_next;
  clsd_pkg::clsd_op_t      op_dec;
  clsd_pkg::clsd_wb_t      wb_reg,     wb_next;
  logic                    pcrel_reg,  pcrel_next;
  logic [31:0]             ext_data;

  // Format recognition on the top opcode bits
  wire [15:0] ins       = instr;
  wire        is_pcrel  = ins[15:11] == clsd_pkg::PCREL_TAG;
  wire        is_regoff = ins[15:12] == clsd_pkg::REGOFF_TAG;
  wire        is_immwb  = ins[15:13] == clsd_pkg::IMMWB_TAG;
  wire        is_immh   = ins[15:12] == clsd_pkg::IMMH_TAG;
  wire        ext_form  = ins[clsd_pkg::EXT_BIT];
  wire        load_bit  = ins[clsd_pkg::LOAD_BIT];
  wire        byte_bit  = ins[clsd_pkg::BYTE_BIT];
  wire        sign_bit  = ins[clsd_pkg::SIGN_BIT];
  wire        half_bit  = ins[clsd_pkg::HALF_BIT];
  wire        immb_bit  = ins[clsd_pkg::IMM_BYTE_BIT];

  // Operation decode per format
  always_comb begin
    op_dec = clsd_pkg::no_op;
    if (is_pcrel) begin
      op_dec = clsd_pkg::word_load_op;
    end else if (is_regoff && !ext_form) begin
      case ({load_bit, byte_bit})
        2'b00:   op_dec = clsd_pkg::word_store_op;
        2'b01:   op_dec = clsd_pkg::byte_store_op;
        2'b10:   op_dec = clsd_pkg::word_load_op;
        default: op_dec = clsd_pkg::byte_load_op;
      endcase
    end else if (is_regoff) begin
      case ({sign_bit, half_bit})
        2'b00:   op_dec = clsd_pkg::half_store_op;
        2'b01:   op_dec = clsd_pkg::half_load_op;
        2'b10:   op_dec = clsd_pkg::signed_byte_load_op;
        default: op_dec = clsd_pkg::signed_half_load_op;
      endcase
    end else if (is_immwb) begin
      case ({load_bit, immb_bit})
        2'b00:   op_dec = clsd_pkg::word_store_op;
        2'b01:   op_dec = clsd_pkg::byte_store_op;
        2'b10:   op_dec = clsd_pkg::word_load_op;
        default: op_dec = clsd_pkg::byte_load_op;
      endcase
    end else if (is_immh) begin
      op_dec = load_bit ? clsd_pkg::half_load_op : clsd_pkg::half_store_op;
    end
  end

  // Three-bit register fields; PC-relative keeps its destination higher up
  wire [2:0] rd_field = is_pcrel ? ins[clsd_pkg::PCRD_LSB +: 3] : ins[clsd_pkg::RD_LSB +: 3];
  assign rf_sel.base_sel  = ins[clsd_pkg::RB_LSB +: 3];
  assign rf_sel.index_sel = ins[clsd_pkg::RO_LSB +: 3];
  assign rf_sel.data_sel  = rd_field;

  // Offsets, scaled per access size
  wire [4:0]  imm_five  = ins[clsd_pkg::OFF5_LSB +: 5];
  wire [7:0]  pc_imm    = ins[clsd_pkg::W8_LSB +: 8];
  wire [31:0] off_byte  = {27'h000_0000, imm_five};
  wire [31:0] off_word  = {25'h000_0000, imm_five, 2'b00};
  wire [31:0] off_half  = {26'h000_0000, imm_five, 1'b0};
  wire [31:0] off_pc    = {22'h00_0000, pc_imm, 2'b00};
  // PC base reads four ahead, bit 1 forced low for word alignment
  wire [31:0] pc_base   = (instr_pc + clsd_pkg::PC_AHEAD) & clsd_pkg::PC_BIT1_CLR;

  // Address select; no format here writes the base back
  wire [31:0] addr_reg  = rf_base_val + rf_index_val;
  wire [31:0] addr_immw = rf_base_val + off_word;
  wire [31:0] addr_immb = rf_base_val + off_byte;
  wire [31:0] addr_immh = rf_base_val + off_half;
  wire [31:0] addr_pc   = pc_base + off_pc;
  wire [31:0] addr_dec  = is_pcrel  ? addr_pc :
                          is_regoff ? addr_reg :
                          is_immwb  ? (immb_bit ? addr_immb : addr_immw) :
                          addr_immh;

  // Access size and direction
  wire op_byte  = (op_dec == clsd_pkg::byte_store_op) || (op_dec == clsd_pkg::byte_load_op)
                || (op_dec == clsd_pkg::signed_byte_load_op);
  wire op_half  = (op_dec == clsd_pkg::half_store_op) || (op_dec == clsd_pkg::half_load_op)
                || (op_dec == clsd_pkg::signed_half_load_op);
  wire op_write = (op_dec == clsd_pkg::word_store_op) || (op_dec == clsd_pkg::byte_store_op)
                || (op_dec == clsd_pkg::half_store_op);
  clsd_pkg::clsd_size_t size_dec;
  assign size_dec = op_byte ? clsd_pkg::SIZE_BYTE :
                    op_half ? clsd_pkg::SIZE_HALF : clsd_pkg::SIZE_WORD;

  // Store data: only the lanes of the access size, upper bits zero
  wire [31:0] wdata_dec = op_byte ? {24'h00_0000, rf_data_val[7:0]} :
                          op_half ? {16'h0000, rf_data_val[15:0]} :
                          rf_data_val;

  // Handshake and completion
  wire accept     = instr_valid && (state_reg == clsd_pkg::ST_IDLE);
  wire bad_op     = op_dec == clsd_pkg::no_op;
  wire store_done = (state_reg == clsd_pkg::ST_ACCESS) && mem_ready && req_reg.write;
  assign instr_ready = state_reg == clsd_pkg::ST_IDLE;
  assign instr_fault = accept && bad_op;
  assign instr_done  = instr_fault || store_done || (state_reg == clsd_pkg::ST_WRITEBACK);
  assign mem_valid   = state_reg == clsd_pkg::ST_ACCESS;
  assign mem_req     = req_reg;
  assign rf_we       = state_reg == clsd_pkg::ST_WRITEBACK;
  assign rf_wb       = wb_reg;

  // Load data extension
  clsd_extend i_clsd_extend (
    .op     (op_reg),
    .raw    (mem_rdata),
    .result (ext_data)
  );

  // Sequencer: store is request then done, load adds a data and a write-back
  // cycle, matching the wide instruction's timing
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    op_next    = op_reg;
    wb_next    = wb_reg;
    pcrel_next = pcrel_reg;
    case (state_reg)
      clsd_pkg::ST_IDLE: begin
        if (accept && !bad_op) begin
          state_next    = clsd_pkg::ST_ACCESS;
          req_next      = '{addr: addr_dec, wdata: wdata_dec, size: size_dec, write: op_write};
          op_next       = op_dec;
          wb_next.sel   = rd_field;
          pcrel_next    = is_pcrel;
        end
      end
      clsd_pkg::ST_ACCESS: begin
        if (mem_ready) begin
          state_next = req_reg.write ? clsd_pkg::ST_IDLE : clsd_pkg::ST_WAIT;
        end
      end
      clsd_pkg::ST_WAIT: begin
        if (mem_rvalid) begin
          state_next   = clsd_pkg::ST_WRITEBACK;
          wb_next.data = ext_data;
        end
      end
      clsd_pkg::ST_WRITEBACK: begin
        state_next = clsd_pkg::ST_IDLE;
      end
      default: begin
        state_next = clsd_pkg::ST_IDLE;
      end
    endcase
  end

  // State and held request
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= clsd_pkg::ST_IDLE;
      req_reg   <= '{addr: clsd_pkg::WORD_RST, wdata: clsd_pkg::WORD_RST,
                     size: clsd_pkg::SIZE_WORD, write: 1'b0};
      op_reg    <= clsd_pkg::no_op;
      wb_reg    <= '{sel: clsd_pkg::SEL_RST, data: clsd_pkg::WORD_RST};
      pcrel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      op_reg    <= op_next;
      wb_reg    <= wb_next;
      pcrel_reg <= pcrel_next;
    end
  end

  // Checks on address forming
  addr_regoff_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_regoff |=> mem_req.addr == $past(rf_base_val + rf_index_val))
    else $error("register offset address wrong");

  imm_byte_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_immwb && immb_bit |=> mem_req.addr == $past(rf_base_val + off_byte))
    else $error("byte immediate address wrong");

  imm_word_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_immwb && !immb_bit
      |=> mem_req.addr == $past(rf_base_val) + {25'h000_0000, $past(imm_five), 2'b00})
    else $error("word immediate address wrong");

  imm_half_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_immh
      |=> mem_req.addr == $past(rf_base_val) + {26'h000_0000, $past(imm_five), 1'b0})
    else $error("halfword immediate address wrong");

  pc_align_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_pcrel && !instr_pc[0] |=> !mem_req.addr[1] && !mem_req.addr[0])
    else $error("pc relative address not word aligned");

  pc_ahead_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_pcrel && instr_pc[1:0] == 2'b00
      |=> mem_req.addr == $past(instr_pc) + 32'h0000_0004 + {22'h00_0000, $past(pc_imm), 2'b00})
    else $error("pc relative offset wrong");

  // Checks on operation decode and store data
  word_byte_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_regoff && !ext_form && {load_bit, byte_bit} == 2'b11
      |=> !mem_req.write && mem_req.size == clsd_pkg::SIZE_BYTE
          && op_reg == clsd_pkg::byte_load_op)
    else $error("byte load not decoded");

  sign_sel_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_regoff && ext_form && {sign_bit, half_bit} == 2'b10
      |=> op_reg == clsd_pkg::signed_byte_load_op && !mem_req.write)
    else $error("signed byte load not decoded");

  half_dir_a: assert property (@(posedge clock) disable iff (reset)
    accept && is_immh |=> mem_req.size == clsd_pkg::SIZE_HALF && mem_req.write == !$past(load_bit))
    else $error("halfword direction wrong");

  byte_store_a: assert property (@(posedge clock) disable iff (reset)
    accept && op_dec == clsd_pkg::byte_store_op
      |=> mem_req.wdata == {24'h00_0000, $past(rf_data_val[7:0])})
    else $error("byte store data wrong");

  half_store_a: assert property (@(posedge clock) disable iff (reset)
    accept && op_dec == clsd_pkg::half_store_op
      |=> mem_req.wdata == {16'h0000, $past(rf_data_val[15:0])})
    else $error("halfword store data wrong");

  // Checks on load extension
  half_zero_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == clsd_pkg::ST_WAIT && mem_rvalid && op_reg == clsd_pkg::half_load_op
      |=> rf_we && rf_wb.data == {16'h0000, $past(mem_rdata[15:0])})
    else $error("unsigned halfword not zero extended");

  sbyte_fill_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == clsd_pkg::ST_WAIT && mem_rvalid && op_reg == clsd_pkg::signed_byte_load_op
      |=> rf_wb.data == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
    else $error("signed byte not extended");

  shalf_fill_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == clsd_pkg::ST_WAIT && mem_rvalid && op_reg == clsd_pkg::signed_half_load_op
      |=> rf_wb.data == {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
    else $error("signed halfword not extended");

  ubyte_zero_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == clsd_pkg::ST_WAIT && mem_rvalid && op_reg == clsd_pkg::byte_load_op
      |=> rf_wb.data == {24'h00_0000, $past(mem_rdata[7:0])})
    else $error("unsigned byte not zero extended");

  // Checks on timing and on the held destination field
  store_time_a: assert property (@(posedge clock) disable iff (reset)
    accept && !bad_op && op_write ##1 mem_ready |-> instr_done ##1 instr_ready)
    else $error("store cycle count wrong");

  load_time_a: assert property (@(posedge clock) disable iff (reset)
    state_reg == clsd_pkg::ST_WAIT && mem_rvalid |=> rf_we && instr_done ##1 instr_ready)
    else $error("load cycle count wrong");

  reg_field_a: assert property (@(posedge clock) disable iff (reset)
    accept && !bad_op |=> rf_wb.sel == $past(rd_field) && op_reg == $past(op_dec))
    else $error("destination field not held");

endmodule : clsd_decode

// ---- bench/clsd_mem_model.sv ----
/*
  Far-side model: the core's low register file and the memory data port.
  Assumes the bench sets stall, lat and regs between instructions.
*/
`timescale 1ns/1ps
module clsd_mem_model (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // Register file side
  input  wire clsd_pkg::clsd_rsel_t    rf_sel,
  output wire logic [31:0]             rf_base_val,
  output wire logic [31:0]             rf_index_val,
  output wire logic [31:0]             rf_data_val,
  input  wire logic                    rf_we,
  input  wire clsd_pkg::clsd_wb_t      rf_wb,
  // Memory side
  input  wire logic                    mem_valid,
  input  wire clsd_pkg::clsd_mem_req_t mem_req,
  output wire logic                    mem_ready,
  output wire logic                    mem_rvalid,
  output wire logic [31:0]             mem_rdata
);
  logic [31:0]             regs [8];
  int                      stall = 0;
  int                      lat   = 1;
  int                      wait_cnt;
  int                      pend;
  int                      req_cnt;
  logic [31:0]             rd_word;
  clsd_pkg::clsd_mem_req_t last_req;

  // Same-cycle reads, like the core's register file
  assign rf_base_val  = regs[rf_sel.base_sel];
  assign rf_index_val = regs[rf_sel.index_sel];
  assign rf_data_val  = regs[rf_sel.data_sel];

  // Data shows only in its slot; inverted otherwise so a stray sample is caught
  assign mem_ready  = mem_valid && (wait_cnt >= stall);
  assign mem_rvalid = (pend == 1);
  assign mem_rdata  = mem_rvalid ? rd_word : ~rd_word;

  // Take requests, schedule load data, apply write-back
  always @(posedge clock) begin
    if (reset) begin
      wait_cnt <= 0;
      pend     <= 0;
      req_cnt  <= 0;
      rd_word  <= 32'h0000_0000;
    end else begin
      if (pend != 0) pend <= pend - 1;
      if (mem_valid && mem_ready) begin
        wait_cnt <= 0;
        req_cnt  <= req_cnt + 1;
        last_req <= mem_req;
        if (!mem_req.write) begin
          pend    <= lat;
          rd_word <= $urandom;
        end
      end else if (mem_valid) begin
        wait_cnt <= wait_cnt + 1;
      end
      if (rf_we) regs[rf_wb.sel] <= rf_wb.data;
    end
  end
endmodule : clsd_mem_model

// ---- bench/tb_compact_isa_load_store_decode.sv ----
/*
  Self-checking bench: hand-picked and random compact load/store instructions.
  Assumes the far-side model answers memory with programmable stall and latency.
*/
`timescale 1ns/1ps
module tb_compact_isa_load_store_decode;
  logic                    clock;
  logic                    reset;
  logic                    instr_valid;
  logic [15:0]             instr;
  logic [31:0]             instr_pc;
  wire logic               instr_ready, instr_done, instr_fault, rf_we;
  wire logic               mem_valid, mem_ready, mem_rvalid;
  wire logic [31:0]        rf_base_val, rf_index_val, rf_data_val, mem_rdata;
  wire clsd_pkg::clsd_rsel_t    rf_sel;
  wire clsd_pkg::clsd_wb_t      rf_wb;
  wire clsd_pkg::clsd_mem_req_t mem_req;
  logic [31:0]             snap [8];
  int                      fail_count = 0;
  int                      n_checks   = 0;
  int                      cycles     = 0;
  logic [15:0]             corner [18] = '{16'h5000, 16'h5400, 16'h5800, 16'h5C00, 16'h5200,
    16'h5600, 16'h5A00, 16'h5E00, 16'h67C0, 16'h6FFF, 16'h77FF, 16'h7FC9, 16'h87C0,
    16'h8FFF, 16'h48FF, 16'h0000, 16'h9000, 16'hFFFF};
  logic [15:0]             ri;
  logic [31:0]             rpc;

  clsd_decode i_clsd_decode (.clock(clock), .reset(reset), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .instr_pc(instr_pc), .instr_done(instr_done),
    .instr_fault(instr_fault), .rf_sel(rf_sel), .rf_base_val(rf_base_val),
    .rf_index_val(rf_index_val), .rf_data_val(rf_data_val), .rf_we(rf_we), .rf_wb(rf_wb),
    .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  clsd_mem_model i_clsd_mem_model (.clock(clock), .reset(reset), .rf_sel(rf_sel),
    .rf_base_val(rf_base_val), .rf_index_val(rf_index_val), .rf_data_val(rf_data_val),
    .rf_we(rf_we), .rf_wb(rf_wb), .mem_valid(mem_valid), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard, well above the under 1400 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Expected request, worked out from the field layout and the register snapshot
  function automatic clsd_pkg::clsd_mem_req_t exp_req(input logic [15:0] i,
                                                      input logic [31:0] pc);
    clsd_pkg::clsd_mem_req_t r;
    logic [31:0]             o;
    o       = {27'h0, i[10:6]};
    r.wdata = snap[i[2:0]];
    r.write = !i[11];
    r.size  = clsd_pkg::SIZE_WORD;
    r.addr  = snap[i[5:3]] + (o << 1);
    if (i[15:11] == 5'h09) begin
      r.addr  = ((pc + 32'h0000_0004) & 32'hFFFF_FFFD) + {22'h0, i[7:0], 2'h0};
      r.write = 1'b0;
    end else if (i[15:12] == 4'h5) begin
      r.addr = snap[i[5:3]] + snap[i[8:6]];
      if (i[9]) begin
        r.write = (i[11:10] == 2'b00);
        r.size  = clsd_pkg::SIZE_HALF;
        if (i[11:10] == 2'b01) r.size = clsd_pkg::SIZE_BYTE;
      end else if (i[10]) begin
        r.size = clsd_pkg::SIZE_BYTE;
      end
    end else if (i[15:13] == 3'h3) begin
      r.addr = snap[i[5:3]] + (i[12] ? o : (o << 2));
      if (i[12]) r.size = clsd_pkg::SIZE_BYTE;
    end else begin
      r.size = clsd_pkg::SIZE_HALF;
    end
    return r;
  endfunction : exp_req

  // Loaded value widened by size, sign fill only for the signed select
  function automatic logic [31:0] exp_load(input logic [15:0] i,
                                           input clsd_pkg::clsd_size_t s,
                                           input logic [31:0] raw);
    logic sgn;
    sgn = (i[15:12] == 4'h5) && i[9] && i[10];
    if (s == clsd_pkg::SIZE_BYTE) return {{24{sgn & raw[7]}}, raw[7:0]};
    if (s == clsd_pkg::SIZE_HALF) return {{16{sgn & raw[15]}}, raw[15:0]};
    return raw;
  endfunction : exp_load

  // One instruction: fresh registers and memory pacing, offer, wait, compare
  task automatic run(input logic [15:0] i, input logic [31:0] pc);
    clsd_pkg::clsd_mem_req_t e, g;
    logic [31:0]             m, v, raw;
    logic [2:0]              rd;
    logic                    ok, f0, d0;
    int                      n, c0;
    @(negedge clock);
    for (int k = 0; k < 8; k++) i_clsd_mem_model.regs[k] = $urandom;
    i_clsd_mem_model.stall = $urandom_range(2);
    i_clsd_mem_model.lat   = $urandom_range(3, 1);
    snap = i_clsd_mem_model.regs;
    e  = exp_req(i, pc);
    ok = (i[15:11] == 5'h09) || (i[15:12] == 4'h5) || (i[15:13] == 3'h3) || (i[15:12] == 4'h8);
    rd = (i[15:11] == 5'h09) ? i[10:8] : i[2:0];
    m  = (e.size == clsd_pkg::SIZE_BYTE) ? 32'h0000_00FF :
         (e.size == clsd_pkg::SIZE_HALF) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    c0 = i_clsd_mem_model.req_cnt;
    instr       = i;
    instr_pc    = pc;
    instr_valid = 1'b1;
    #1;
    f0 = instr_fault;
    d0 = instr_done;
    chk({31'h0, instr_ready}, 32'h0000_0001);
    @(negedge clock);
    instr_valid = 1'b0;
    n = 1;
    while (d0 !== 1'b1 && instr_done !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    #1;
    g   = i_clsd_mem_model.last_req;
    v   = i_clsd_mem_model.regs[rd];
    raw = i_clsd_mem_model.rd_word;
    chk({31'h0, f0}, {31'h0, !ok});
    chk({31'h0, instr_done}, 32'h0000_0000);
    // Only a load's destination may change; no base write-back
    for (int k = 0; k < 8; k++) begin
      if (!ok || e.write || k != rd) chk(i_clsd_mem_model.regs[k], snap[k]);
    end
    if (!ok) begin
      chk({31'h0, d0}, 32'h0000_0001);
      chk(i_clsd_mem_model.req_cnt - c0, 32'h0000_0000);
    end else begin
      chk(n, e.write ? 1 + i_clsd_mem_model.stall :
             2 + i_clsd_mem_model.stall + i_clsd_mem_model.lat);
      chk(g.addr, e.addr);
      chk(32'(g.size), 32'(e.size));
      chk({31'h0, g.write}, {31'h0, e.write});
      if (e.write) chk(g.wdata, e.wdata & m);
      else chk(v, exp_load(i, e.size, raw));
    end
  endtask : run

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Reset, every corner once, then random traffic across the four formats
  initial begin
    reset       = 1'b1;
    instr_valid = 1'b0;
    instr       = 16'h0000;
    instr_pc    = 32'h0000_0000;
    void'($urandom(98));
    repeat (8) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    foreach (corner[k]) run(corner[k], (32'($urandom_range(32'hFFFF)) << 2) | 32'h0000_0002);
    repeat (150) begin
      ri  = 16'($urandom);
      rpc = $urandom;
      rpc[0] = 1'b0;
      case ($urandom_range(3))
        0: ri[15:11] = 5'h09;
        1: ri[15:12] = 4'h5;
        2: ri[15:13] = 3'h3;
        default: ri[15:12] = 4'h8;
      endcase
      run(ri, rpc);
    end
    report_and_stop();
  end
endmodule : tb_compact_isa_load_store_decode
